// File: common/pcs_map.svh
// Purpose: offsets, field positions, reset values and vectors of the
//          program counter and return stack block
// Assumes: 32-bit AXI4-Lite data, one register per aligned word
// Notes:   definitions only
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

// register byte offsets
`define PCS_OFS_PCL      8'h00
`define PCS_OFS_LATH     8'h04
`define PCS_OFS_LATU     8'h08
`define PCS_OFS_RETURN_STACK_POINTER_REG   8'h0C
`define PCS_OFS_TOPL     8'h10
`define PCS_OFS_TOPH     8'h14
`define PCS_OFS_TOPU     8'h18
`define PCS_OFS_CFG      8'h1C
`define PCS_OFS_PCFULL   8'h20

// widths and depth
`define PCS_PC_W         21
`define PCS_SP_W         5
`define PCS_STK_TOP      5'h1F
`define PCS_STK_LAST     5'h1E

// vectors and steps
`define PCS_VEC_RESET    21'h000000
`define PCS_VEC_HI       21'h000008
`define PCS_VEC_LO       21'h000018
`define PCS_PC_STEP      21'h000002
`define PCS_CFG_SPAN     21'h000007

// program memory tops for size selects 16, 32 and 64 Kbyte
`define PCS_TOP_16K      21'h003FFF
`define PCS_TOP_32K      21'h007FFF
`define PCS_TOP_64K      21'h00FFFF

// stack pointer register fields
`define PCS_SPR_FULL     7
`define PCS_SPR_UNF      6

// configuration: erased value and overflow reset enable position
`define PCS_CFG_RST      16'hFFFF
`define PCS_CFG_OVR_BIT  5

// bus answers
`define PCS_RESP_OK      2'h0
`define PCS_RESP_ERR     2'h2
`define PCS_ZERO32       32'h00000000
`endif

// File: common/pcs_pkg.sv
// Purpose: types of the program counter and return stack block
// Assumes: constants come from pcs_map.svh
// Notes:   state of the core is one packed struct
`include "pcs_map.svh"
package pcs_pkg;

  typedef enum logic [3:0] {
    PCS_OP_NONE, PCS_OP_STEP, PCS_OP_JUMP, PCS_OP_CALL, PCS_OP_IRQ_HI,
    PCS_OP_IRQ_LO, PCS_OP_RET, PCS_OP_LINK_RET, PCS_OP_PUSH, PCS_OP_POP
  } pcs_op_e;

  typedef enum logic [1:0] {PCS_LOAD, PCS_DRAIN, PCS_RUN} pcs_phase_e;

  // request from the instruction sequencer
  typedef struct packed {
    pcs_op_e                op;
    logic [`PCS_PC_W-1:0]   target;
  } pcs_seq_s;

  typedef struct packed {
    pcs_phase_e                         phase;
    logic [`PCS_PC_W-1:0]               pc;
    logic [7:0]                         lath;
    logic [4:0]                         latu;
    logic [`PCS_SP_W-1:0]               sp;
    logic                               full;
    logic                               unf;
    logic [31:0][`PCS_PC_W-1:0]         stk;
    logic [3:0][15:0]                   cfg;
    logic [1:0]                         cidx;
    logic                               pend;
    logic [1:0]                         pidx;
    logic [`PCS_PC_W-1:0]               maddr;
    logic                               oor;
    logic [15:0]                        instr;
    logic                               ivalid;
    logic                               dev_rst;
    logic                               aw_v;
    logic [7:0]                         aw_a;
    logic                               w_v;
    logic [31:0]                        w_d;
    logic [3:0]                         w_s;
    logic                               awrdy;
    logic                               wrdy;
    logic                               bvalid;
    logic [1:0]                         bresp;
    logic                               arrdy;
    logic                               rvalid;
    logic [31:0]                        rdata;
    logic [1:0]                         rresp;
    logic                               srdy;
  } pcs_state_s;

endpackage

// File: core/pcs_core.sv
// Purpose: program counter, latches and 31-entry return stack with
//          AXI4-Lite register access and configuration word load
// Assumes: program memory answers while mem_addr stands, taken at next edge
// Notes:   sequencer requests are taken only while seq_ready is high
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`include "pcs_map.svh"

// How it works
// - a 21-bit counter addresses a 2-Mbyte byte program space
// - fetches above implemented memory return zero, a no-operation
// - every device reset loads the counter with 0000h
// - high priority interrupt vectors to 0008h, low to 0018h
// - top four memory words are copied to configuration after reset
// - configuration bytes ascend from the last eight bytes of memory
// - only the low byte is direct; middle and upper change via latches
// - writing the low byte loads middle and upper from the latches
// - reading the low byte copies middle and upper into the latches
// - bit 0 stays zero and sequential fetches add two
// - calls, gotos and branches load the counter without the latches
// - stack is 31 entries of 21 bits with a 5-bit pointer
// - calls and interrupts push, returns pop, latches stay untouched
// - push increments then writes; pop reads then decrements
// - resets clear the pointer; pointer zero has no entry
// - three top registers read and write the selected stack entry
// - software reads and writes the pointer, range 0 to 31
// - the 31st push sets full; only software or power-on clears it
// - overflow reset on: 31st push stores counter plus two and resets
// - overflow reset off: pointer stops at 31, entry 31 kept
// - pop at zero loads zero, sets underflow, pointer stays zero
// - pointer register holds full, underflow, zero bit, 5-bit pointer
module pcs_core
  import pcs_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [7:0]           awaddr,
  input  wire logic                 wvalid,
  output logic                      wready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  output logic                      bvalid,
  input  wire logic                 bready,
  output logic [1:0]                bresp,
  input  wire logic                 arvalid,
  output logic                      arready,
  input  wire logic [7:0]           araddr,
  output logic                      rvalid,
  input  wire logic                 rready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  input  wire pcs_seq_s             seq_req,
  output logic                      seq_ready,
  input  wire logic                 ext_set_en,
  input  wire logic                 dev_reset_in,
  input  wire logic [1:0]           mem_size_sel,
  output logic [`PCS_PC_W-1:0]      mem_addr,
  input  wire logic [15:0]          mem_rdata,
  output logic [15:0]               instr_word,
  output logic                      instr_valid,
  output logic [`PCS_PC_W-1:0]      prog_counter,
  output logic [63:0]               cfg_words,
  output logic                      dev_reset_out
);

  pcs_state_s s, n;
  logic [`PCS_PC_W-1:0] mem_top;
  logic                 ovr_en;
  logic                 sw_wr;
  logic                 seq_go;

  // implemented memory top from the size select
  always_comb begin
    unique case (mem_size_sel)
      2'h0:    mem_top = `PCS_TOP_16K;
      2'h1:    mem_top = `PCS_TOP_32K;
      default: mem_top = `PCS_TOP_64K;
    endcase
  end

  assign ovr_en = s.cfg[0][`PCS_CFG_OVR_BIT];
  assign sw_wr  = ce && s.aw_v && s.w_v && !s.bvalid;
  assign seq_go = ce && (s.phase == PCS_RUN) && (seq_req.op != PCS_OP_NONE);

  // next state: bus, software access, sequencer, config load, fetch
  always_comb begin
    logic [`PCS_PC_W-1:0] ret;
    logic                 do_push;
    logic                 do_pop;
    logic                 rst_now;
    ret     = s.pc;
    do_push = 1'b0;
    do_pop  = 1'b0;
    rst_now = dev_reset_in;
    n         = s;
    n.dev_rst = 1'b0;
    // bus channel capture
    if (awvalid && s.awrdy) begin
      n.aw_v = 1'b1;
      n.aw_a = awaddr;
    end
    if (wvalid && s.wrdy) begin
      n.w_v = 1'b1;
      n.w_d = wdata;
      n.w_s = wstrb;
    end
    if (s.bvalid && bready)
      n.bvalid = 1'b0;
    if (s.rvalid && rready)
      n.rvalid = 1'b0;
    // register write, low byte lane carries every field
    if (sw_wr) begin
      n.aw_v   = 1'b0;
      n.w_v    = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = `PCS_RESP_OK;
      unique case (s.aw_a)
        `PCS_OFS_PCL: if (s.w_s[0])
          n.pc = {s.latu, s.lath, s.w_d[7:1], 1'b0};
        `PCS_OFS_LATH: if (s.w_s[0])
          n.lath = s.w_d[7:0];
        `PCS_OFS_LATU: if (s.w_s[0])
          n.latu = s.w_d[4:0];
        `PCS_OFS_RETURN_STACK_POINTER_REG: if (s.w_s[0]) begin
          n.sp   = s.w_d[`PCS_SP_W-1:0];
          n.full = s.full & s.w_d[`PCS_SPR_FULL];
          n.unf  = s.unf & s.w_d[`PCS_SPR_UNF];
        end
        `PCS_OFS_TOPL: if (s.w_s[0] && s.sp != 5'h00)
          n.stk[s.sp][7:0] = s.w_d[7:0];
        `PCS_OFS_TOPH: if (s.w_s[0] && s.sp != 5'h00)
          n.stk[s.sp][15:8] = s.w_d[7:0];
        `PCS_OFS_TOPU: if (s.w_s[0] && s.sp != 5'h00)
          n.stk[s.sp][20:16] = s.w_d[4:0];
        `PCS_OFS_CFG, `PCS_OFS_PCFULL: ;
        default: n.bresp = `PCS_RESP_ERR;
      endcase
    end
    // register read
    if (ce && arvalid && s.arrdy) begin
      n.rvalid = 1'b1;
      n.rresp  = `PCS_RESP_OK;
      n.rdata  = `PCS_ZERO32;
      unique case (araddr)
        `PCS_OFS_PCL: begin
          n.rdata[7:0] = n.pc[7:0];
          n.lath       = n.pc[15:8];
          n.latu       = n.pc[20:16];
        end
        `PCS_OFS_LATH:   n.rdata[7:0] = n.lath;
        `PCS_OFS_LATU:   n.rdata[4:0] = n.latu;
        `PCS_OFS_RETURN_STACK_POINTER_REG:
          n.rdata[7:0] = {n.full, n.unf, 1'b0, n.sp};
        `PCS_OFS_TOPL:   n.rdata[7:0] = n.stk[n.sp][7:0];
        `PCS_OFS_TOPH:   n.rdata[7:0] = n.stk[n.sp][15:8];
        `PCS_OFS_TOPU:   n.rdata[4:0] = n.stk[n.sp][20:16];
        `PCS_OFS_CFG:    n.rdata[15:0] = s.cfg[0];
        `PCS_OFS_PCFULL: n.rdata[`PCS_PC_W-1:0] = n.pc;
        default:         n.rresp = `PCS_RESP_ERR;
      endcase
    end
    // sequencer operation; applied after software so its flags win
    if (seq_go) begin
      unique case (seq_req.op)
        PCS_OP_STEP: n.pc = n.pc + `PCS_PC_STEP;
        PCS_OP_JUMP:
          n.pc = {seq_req.target[20:1], 1'b0};
        PCS_OP_CALL: begin
          do_push = 1'b1;
          n.pc    = {seq_req.target[20:1], 1'b0};
        end
        PCS_OP_IRQ_HI: begin
          do_push = 1'b1;
          n.pc    = `PCS_VEC_HI;
        end
        PCS_OP_IRQ_LO: begin
          do_push = 1'b1;
          n.pc    = `PCS_VEC_LO;
        end
        PCS_OP_RET: do_pop = 1'b1;
        PCS_OP_LINK_RET:
          if (ext_set_en)
            do_pop = 1'b1;
          else
            n.pc = n.pc + `PCS_PC_STEP;
        PCS_OP_PUSH: begin
          do_push = 1'b1;
          n.pc    = n.pc + `PCS_PC_STEP;
        end
        PCS_OP_POP: begin
          if (n.sp != 5'h00)
            n.sp = n.sp - 5'h01;
          n.pc = n.pc + `PCS_PC_STEP;
        end
        default: ;
      endcase
      ret = n.sp == 5'h00 ? s.pc : s.pc;
    end
    // push: pointer first, then the entry it selects
    if (do_push) begin
      ret = (seq_req.op == PCS_OP_PUSH) ? s.pc : s.pc;
      if (n.sp == `PCS_STK_LAST) begin
        n.full = 1'b1;
        if (ovr_en) begin
          n.stk[`PCS_STK_TOP] = ret + `PCS_PC_STEP;
          rst_now = 1'b1;
        end else begin
          n.stk[`PCS_STK_TOP] = ret;
          n.sp = `PCS_STK_TOP;
        end
      end else if (n.sp == `PCS_STK_TOP) begin
        n.full = 1'b1;
      end else begin
        n.sp        = n.sp + 5'h01;
        n.stk[n.sp] = ret;
      end
    end
    // pop: entry first, then the pointer
    if (do_pop) begin
      if (n.sp == 5'h00) begin
        n.pc  = `PCS_VEC_RESET;
        n.unf = 1'b1;
      end else begin
        n.pc = {n.stk[n.sp][20:1], 1'b0};
        n.sp = n.sp - 5'h01;
      end
    end
    // device reset: counter and pointer cleared, flags kept
    if (ce && rst_now) begin
      n.pc      = `PCS_VEC_RESET;
      n.sp      = 5'h00;
      n.phase   = PCS_LOAD;
      n.cidx    = 2'h0;
      n.dev_rst = 1'b1;
      n.ivalid  = 1'b0;
    end else if (ce) begin
      // configuration words, ascending from top of memory minus seven
      if (s.pend)
        n.cfg[s.pidx] = mem_rdata;
      n.pend = 1'b0;
      unique case (s.phase)
        PCS_LOAD: begin
          n.maddr = mem_top - `PCS_CFG_SPAN
                    + {18'h00000, s.cidx, 1'b0};
          n.pend  = 1'b1;
          n.pidx  = s.cidx;
          n.cidx  = s.cidx + 2'h1;
          if (s.cidx == 2'h3)
            n.phase = PCS_DRAIN;
        end
        PCS_DRAIN: begin
          n.phase = PCS_RUN;
          n.maddr = n.pc;
          n.oor   = n.pc > mem_top;
        end
        PCS_RUN: begin
          n.instr  = s.oor ? 16'h0000 : mem_rdata;
          n.ivalid = 1'b1;
          n.maddr  = n.pc;
          n.oor    = n.pc > mem_top;
        end
        default: n.phase = PCS_LOAD;
      endcase
    end
    n.stk[0] = '0;
    n.awrdy  = !n.aw_v && !n.bvalid;
    n.wrdy   = !n.w_v && !n.bvalid;
    n.arrdy  = !n.rvalid;
    n.srdy   = n.phase == PCS_RUN;     // registered sequencer gate
  end

  // state register, power-on reset clears every flag except dev_rst, which it sets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s        <= '0;
      s.phase  <= PCS_LOAD;
      s.cfg    <= {4{`PCS_CFG_RST}};
      s.dev_rst <= 1'b1;
    end else if (ce) begin
      s <= n;
    end
  end

  assign awready       = s.awrdy;
  assign wready        = s.wrdy;
  assign bvalid        = s.bvalid;
  assign bresp         = s.bresp;
  assign arready       = s.arrdy;
  assign rvalid        = s.rvalid;
  assign rdata         = s.rdata;
  assign rresp         = s.rresp;
  assign seq_ready     = s.srdy;
  assign mem_addr      = s.maddr;
  assign instr_word    = s.instr;
  assign instr_valid   = s.ivalid;
  assign prog_counter  = s.pc;
  assign cfg_words     = s.cfg;
  assign dev_reset_out = s.dev_rst;

  // checks
  logic quiet;
  assign quiet = seq_go && !sw_wr && !dev_reset_in;

  property p_step;
    @(posedge aclk) disable iff (!aresetn)
    quiet && seq_req.op == PCS_OP_STEP |=>
      prog_counter == $past(s.pc) + `PCS_PC_STEP && !prog_counter[0];
  endproperty
  a_step: assert property (p_step) else $error("step not two");

  property p_irq_hi;
    @(posedge aclk) disable iff (!aresetn)
    quiet && seq_req.op == PCS_OP_IRQ_HI && s.sp < `PCS_STK_LAST |=>
      prog_counter == `PCS_VEC_HI && s.sp == $past(s.sp) + 5'h01
      && s.stk[s.sp] == $past(s.pc) && s.lath == $past(s.lath);
  endproperty
  a_irq_hi: assert property (p_irq_hi) else $error("hi vector");

  property p_irq_lo;
    @(posedge aclk) disable iff (!aresetn)
    quiet && seq_req.op == PCS_OP_IRQ_LO && s.sp < `PCS_STK_LAST |=>
      prog_counter == `PCS_VEC_LO;
  endproperty
  a_irq_lo: assert property (p_irq_lo) else $error("lo vector");

  property p_pop;
    @(posedge aclk) disable iff (!aresetn)
    quiet && seq_req.op == PCS_OP_RET && s.sp != 5'h00 |=>
      prog_counter == {$past(s.stk[s.sp][20:1]), 1'b0}
      && s.sp == $past(s.sp) - 5'h01;
  endproperty
  a_pop: assert property (p_pop) else $error("pop order");

  property p_unf;
    @(posedge aclk) disable iff (!aresetn)
    quiet && seq_req.op == PCS_OP_RET && s.sp == 5'h00 |=>
      prog_counter == `PCS_VEC_RESET && s.unf && s.sp == 5'h00
      && !dev_reset_out;
  endproperty
  a_unf: assert property (p_unf) else $error("underflow");

  property p_ovr_on;
    @(posedge aclk) disable iff (!aresetn)
    quiet && (seq_req.op == PCS_OP_CALL || seq_req.op == PCS_OP_PUSH)
    && s.sp == `PCS_STK_LAST && ovr_en
    |=> s.full && s.sp == 5'h00 && dev_reset_out
      && s.stk[`PCS_STK_TOP] == $past(s.pc) + `PCS_PC_STEP;
  endproperty
  a_ovr_on: assert property (p_ovr_on) else $error("ovr reset");

  property p_ovr_off;
    @(posedge aclk) disable iff (!aresetn)
    quiet && (seq_req.op == PCS_OP_CALL || seq_req.op == PCS_OP_PUSH)
    && s.sp >= `PCS_STK_LAST && !ovr_en
    |=> s.full && s.sp == `PCS_STK_TOP ##1 !dev_reset_out;
  endproperty
  a_ovr_off: assert property (p_ovr_off) else $error("ovr hold");

  property p_dev_rst;
    @(posedge aclk) disable iff (!aresetn)
    ce && dev_reset_in |=> prog_counter == `PCS_VEC_RESET
      && s.sp == 5'h00 && !seq_ready [*4];
  endproperty
  a_dev_rst: assert property (p_dev_rst) else $error("dev reset");

  property p_full_sticky;
    @(posedge aclk) disable iff (!aresetn)
    s.full && !sw_wr |=> s.full;
  endproperty
  a_full_sticky: assert property (p_full_sticky) else $error("full lost");

endmodule

// File: test/pcs_prog_mem.sv
// Purpose: program memory model behind the counter block
// Assumes: word answered while the address stands, taken at next edge
// Notes:   each word reads as its address with bit 0 set
`timescale 1ns/10ps
`include "pcs_map.svh"
module pcs_prog_mem
  import pcs_pkg::*;
(
  input  wire logic [1:0]           mem_size_sel,
  input  wire logic                 ovr_off,
  input  wire logic [`PCS_PC_W-1:0] mem_addr,
  output logic [15:0]               mem_rdata
);
  logic [`PCS_PC_W-1:0] top;
  // top of implemented memory from the size select
  always_comb begin
    top = (mem_size_sel == 2'h0) ? `PCS_TOP_16K :
          (mem_size_sel == 2'h1) ? `PCS_TOP_32K : `PCS_TOP_64K;
  end
  // first config word may drop its overflow reset enable
  always_comb begin
    mem_rdata = {mem_addr[15:1], 1'b1};
    if (ovr_off && mem_addr == top - `PCS_CFG_SPAN) begin
      mem_rdata[`PCS_CFG_OVR_BIT] = 1'b0;
    end
  end
endmodule

// File: test/test_program_counter_return_stack.sv
// Purpose: self-checking bench of the counter and return stack
// Assumes: register answers taken at the response handshake
// Notes:   expected answers queued by the driver, checked by a monitor
`timescale 1ns/10ps
`include "pcs_map.svh"
module test_program_counter_return_stack;
  import pcs_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, seq_ready;
  logic        ext_set_en, dev_reset_in, instr_valid, dev_reset_out;
  logic        ovr_off, ce;
  logic [7:0]  awaddr, araddr, lh, lb;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, mem_size_sel;
  logic [15:0] mem_rdata, instr_word;
  logic [4:0]  lu;
  logic [63:0] cfg_words;
  logic [`PCS_PC_W-1:0] mem_addr, prog_counter, t, p;
  pcs_seq_s    seq_req;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [15:0] iq[$];
  int          n_mismatch, total_checks, i;
  event        ins_ev;

  pcs_core u_pcs_core (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .seq_req(seq_req), .seq_ready(seq_ready), .ext_set_en(ext_set_en),
    .dev_reset_in(dev_reset_in), .mem_size_sel(mem_size_sel),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .instr_word(instr_word), .instr_valid(instr_valid),
    .prog_counter(prog_counter), .cfg_words(cfg_words),
    .dev_reset_out(dev_reset_out));
  pcs_prog_mem u_pcs_prog_mem (
    .mem_size_sel(mem_size_sel), .ovr_off(ovr_off),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata));

  // clock and watchdog
  initial aclk = 1'b0;
  always #5 aclk = ~aclk;
  initial begin
    #500000;
    n_mismatch++;
    test_done();
  end

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic miss(input logic [33:0] e, input logic [33:0] g);
    n_mismatch++;
    $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
  endtask
  task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
    total_checks++;
    if (e[33:32] == `PCS_RESP_ERR ? g[33:32] !== e[33:32] : g !== e)
      miss(e, g);
  endtask
  task automatic cmp_wr(input logic [1:0] e, input logic [1:0] g);
    total_checks++;
    if (g !== e) miss({32'h0, e}, {32'h0, g});
  endtask
  task automatic cmp_ins(input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) miss({18'h0, e}, {18'h0, g});
  endtask

  // monitor: each answer takes the oldest note
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1)
      cmp_rd(rq.pop_front(), {rresp, rdata});
    if (bvalid === 1'b1 && bready === 1'b1)
      cmp_wr(bq.pop_front(), bresp);
  end
  always @(ins_ev) begin
    cmp_ins(iq.pop_front(), instr_word);
    cmp_ins(16'h0001, {15'h0, instr_valid});
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = `PCS_RESP_OK);
    int   n;
    logic pa, pw;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bq.push_back(r);
    pa = 1'b1;
    pw = 1'b1;
    n = 0;
    while ((pa || pw || bvalid !== 1'b1) && n < 200) begin
      @(posedge aclk);
      n++;
      if (pa && awready === 1'b1) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (pw && wready === 1'b1) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    bready <= 1'b0;
    if (n >= 200) n_mismatch++;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r = `PCS_RESP_OK);
    int   n;
    logic pa;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rq.push_back({r, e});
    pa = 1'b1;
    n = 0;
    while ((pa || rvalid !== 1'b1) && n < 200) begin
      @(posedge aclk);
      n++;
      if (pa && arready === 1'b1) begin
        arvalid <= 1'b0;
        pa = 1'b0;
      end
    end
    rready <= 1'b0;
    if (n >= 200) n_mismatch++;
  endtask
  task automatic wait_run();
    int n;
    repeat (2) @(posedge aclk);
    for (n = 0; n < 50 && seq_ready !== 1'b1; n++) @(posedge aclk);
  endtask
  task automatic seq(input pcs_op_e o, input logic [`PCS_PC_W-1:0] tg);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (seq_ready !== 1'b1 && n < 200);
    seq_req <= {o, tg};
    @(posedge aclk);
    seq_req.op <= PCS_OP_NONE;
  endtask
  task automatic fetch(input logic [15:0] e);
    repeat (4) @(posedge aclk);
    #1;
    iq.push_back(e);
    -> ins_ev;
  endtask
  task automatic dev_rst();
    @(posedge aclk);
    dev_reset_in <= 1'b1;
    @(posedge aclk);
    dev_reset_in <= 1'b0;
    wait_run();
  endtask
  task automatic pc_is(input logic [`PCS_PC_W-1:0] v);
    rd(`PCS_OFS_PCFULL, {11'h0, v});
  endtask
  task automatic sp_is(input logic [7:0] v);
    rd(`PCS_OFS_RETURN_STACK_POINTER_REG, {24'h0, v});
  endtask
  task automatic top(input logic [`PCS_PC_W-1:0] v);
    rd(`PCS_OFS_TOPL, {24'h0, v[7:0]});
    rd(`PCS_OFS_TOPH, {24'h0, v[15:8]});
    rd(`PCS_OFS_TOPU, {27'h0, v[20:16]});
  endtask

  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, seq_req} = '0;
    {ext_set_en, dev_reset_in, mem_size_sel, ovr_off} = '0;
    ce = 1'b1;
    n_mismatch = 0;
    total_checks = 0;
    void'($urandom(68294));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    wait_run();
    for (i = 0; i < 3; i++) begin
      mem_size_sel <= i[1:0];
      if (i != 0) dev_rst();
      p = (i == 0) ? `PCS_TOP_16K : (i == 1) ? `PCS_TOP_32K : `PCS_TOP_64K;
      rd(`PCS_OFS_CFG, {16'h0, p[15:0] - 16'h6});
      cmp_ins(p[15:0], cfg_words[63:48]);
      pc_is(`PCS_VEC_RESET);
      sp_is(8'h00);
      seq(PCS_OP_JUMP, p + 21'h1);
      fetch(16'h0);
      seq(PCS_OP_JUMP, p - 21'h1F);
      fetch(p[15:0] - 16'h1E);
    end
    seq(PCS_OP_JUMP, 21'h1FFFFF);
    pc_is(21'h1FFFFE);
    lh = 8'($urandom);
    lu = 5'($urandom);
    lb = 8'($urandom);
    t = 21'($urandom) & 21'h1FFFFE;
    wr(`PCS_OFS_LATH, {24'h0, lh});
    wr(`PCS_OFS_LATU, {27'h0, lu});
    pc_is(21'h1FFFFE);
    wr(`PCS_OFS_PCL, {24'h0, lb});
    pc_is({lu, lh, lb[7:1], 1'b0});
    seq(PCS_OP_JUMP, t);
    pc_is(t);
    rd(`PCS_OFS_LATH, {24'h0, lh});
    rd(`PCS_OFS_PCL, {24'h0, t[7:0]});
    rd(`PCS_OFS_LATH, {24'h0, t[15:8]});
    rd(`PCS_OFS_LATU, {27'h0, t[20:16]});
    seq(PCS_OP_STEP, 21'h0);
    p = t + `PCS_PC_STEP;
    pc_is(p);
    // clock enable low: a held step must not move the counter
    ce <= 1'b0;
    seq_req.op <= PCS_OP_STEP;
    repeat (3) @(posedge aclk);
    seq_req.op <= PCS_OP_NONE;
    ce <= 1'b1;
    pc_is(p);
    seq(PCS_OP_CALL, 21'h100);
    sp_is(8'h01);
    top(p);
    seq(PCS_OP_IRQ_HI, 21'h0);
    pc_is(`PCS_VEC_HI);
    top(21'h100);
    seq(PCS_OP_IRQ_LO, 21'h0);
    pc_is(`PCS_VEC_LO);
    sp_is(8'h03);
    seq(PCS_OP_RET, 21'h0);
    pc_is(`PCS_VEC_HI);
    rd(`PCS_OFS_LATH, {24'h0, t[15:8]});
    wr(`PCS_OFS_TOPL, 32'h34);
    wr(`PCS_OFS_TOPH, 32'h12);
    wr(`PCS_OFS_TOPU, 32'h01);
    seq(PCS_OP_RET, 21'h0);
    pc_is(21'h011234);
    ext_set_en <= 1'b1;
    seq(PCS_OP_LINK_RET, 21'h0);
    pc_is(p);
    ext_set_en <= 1'b0;
    seq(PCS_OP_LINK_RET, 21'h0);
    pc_is(p + `PCS_PC_STEP);
    wr(`PCS_OFS_RETURN_STACK_POINTER_REG, 32'h03);
    sp_is(8'h03);
    wr(`PCS_OFS_RETURN_STACK_POINTER_REG, 32'h00);
    seq(PCS_OP_RET, 21'h0);
    pc_is(21'h0);
    sp_is(8'h40);
    rd(`PCS_OFS_TOPL, 32'h0);
    wr(`PCS_OFS_RETURN_STACK_POINTER_REG, 32'h00);
    sp_is(8'h00);
    for (i = 0; i < 31; i++) seq(PCS_OP_PUSH, 21'h0);
    wait_run();
    sp_is(8'h80);
    pc_is(`PCS_VEC_RESET);
    wr(`PCS_OFS_RETURN_STACK_POINTER_REG, 32'h1F);
    sp_is(8'h1F);
    top(21'd62);
    ovr_off <= 1'b1;
    dev_rst();
    rd(`PCS_OFS_CFG, 32'hFFD9);
    sp_is(8'h00);
    for (i = 0; i < 32; i++) seq(PCS_OP_PUSH, 21'h0);
    sp_is(8'h9F);
    top(21'd60);
    seq(PCS_OP_POP, 21'h0);
    sp_is(8'h9E);
    top(21'd58);
    rd(8'h40, 32'h0, `PCS_RESP_ERR);
    wr(8'h40, 32'h0, `PCS_RESP_ERR);
    test_done();
  end
endmodule
